// File: hw/parallel_target_port_pkg.sv
/*
 parallel_target_port_pkg: register offsets, field positions, reset values and bus states
 for the parallel target port control block.
 Assumes a 32-bit Avalon-MM slave port with byte addressing, one register per aligned word.
*/
package parallel_target_port_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// byte addresses on the register bus
	localparam logic [ADDR_W-1:0] OFS_PORT_D_DATA  = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_PORT_E_DATA  = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_PORT_D_DIR   = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_PORT_E_DIR   = 8'h2C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL  = 8'h30;
	localparam logic [ADDR_W-1:0] OFS_CONV_CONFIG  = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_RX_FIFO_DATA = 8'h38;
	localparam logic [ADDR_W-1:0] OFS_PORT_STATUS  = 8'h3C;
	localparam logic [ADDR_W-1:0] OFS_PERIPH_IRQ_EN = 8'h8C;

	// port E pin roles while the parallel target port is selected
	localparam int PIN_READ_N   = 0;
	localparam int PIN_WRITE_N  = 1;
	localparam int PIN_SELECT_N = 2;
	localparam int PORT_E_PINS  = 3;

	// field positions
	localparam int PARALLEL_PORT_SELECT_BIT = 4;
	localparam int PERIPH_IRQ_GATE_BIT      = 6;
	localparam int PORT_TRANSFER_IRQ_EN_BIT = 7;
	localparam int STATUS_XFER_FLAG_BIT     = 0;
	localparam int STATUS_FIFO_EMPTY_BIT    = 1;
	localparam int STATUS_FIFO_FULL_BIT     = 2;
	localparam int STATUS_PUSH_STALL_BIT    = 3;

	// reset values
	localparam logic [7:0] RST_PERIPH_IRQ_EN = 8'h00;
	localparam logic [7:0] RST_IRQ_CONTROL   = 8'h00;
	localparam logic [7:0] RST_PORT_D_DIR    = 8'hFF;
	localparam logic [7:0] RST_PORT_E_DIR    = 8'h07;
	localparam logic [7:0] RST_CONV_CONFIG   = 8'h07;
	localparam logic [7:0] RST_PORT_DATA     = 8'h00;
	localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

	localparam int RX_FIFO_DEPTH = 32;

	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b00,
		BUS_ANSWER = 2'b01
	} bus_state_t;

endpackage : parallel_target_port_pkg

// File: hw/parallel_target_port_control.sv
/*
 parallel_target_port_control: port D / port E pin logic with the parallel target port,
 the peripheral interrupt enable register and an Avalon-MM register slave; also holds
 rx_byte_fifo, which buffers bytes written by the external processor.
 Assumes pin inputs already synchronous to core_clk and an Avalon-MM master that
 holds each request until it samples waitrequest low.
*/
`timescale 1ns/1ps
`default_nettype none

module rx_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PTR_W = $clog2(DEPTH);

	typedef struct packed {
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [PTR_W:0]   count;
	} fifo_state_t;

	fifo_state_t      st_r;
	fifo_state_t      st_nxt;
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic             push;
	logic             pop;

	assign in_ready  = (st_r.count != (PTR_W+1)'(DEPTH));
	assign out_valid = (st_r.count != '0);
	assign out_data  = mem_r[st_r.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
		end
		if (pop) begin
			st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
		end
		// depth must be a power of two so the pointers wrap by themselves
		case ({push, pop})
			2'b10:   st_nxt.count = st_r.count + 1'b1;
			2'b01:   st_nxt.count = st_r.count - 1'b1;
			default: st_nxt.count = st_r.count;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_r[st_r.wr_ptr] <= in_data;
		end
	end

endmodule : rx_byte_fifo

// What this block does
// - each port E pin has its own direction bit choosing input or output
// - port E direction bit 4 turns the three port E pins into strobes
// - port E pins set as analog read back as zero
// - port E direction bits still govern the pins while they are analog
// - after reset port E pins are analog and read back zero
// - read strobe low with select low drives port D register onto port D pins
// - write strobe low with select low latches port D pins into port D register
// - select is active low; deselected, read and write strobes do nothing
// - port D pins are the external data bus in strobe mode, else plain I/O
// - peripheral enable register: one read/write bit per source, reset zero
// - no peripheral request passes unless the gate bit 6 is set
// - enable bits 7..0: port, converter, rx, tx, sync serial, cmp1, t2, t1
module parallel_target_port_control
	import parallel_target_port_pkg::*;
#(
	parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
	input  wire logic                   core_clk,
	input  wire logic                   arst_n,
	input  wire logic [ADDR_W-1:0]      address,
	input  wire logic                   read,
	input  wire logic                   write,
	input  wire logic [DATA_W-1:0]      writedata,
	input  wire logic [3:0]             byteenable,
	output logic [DATA_W-1:0]           readdata,
	output logic                        waitrequest,
	input  wire logic [7:0]             port_d_in,
	output logic [7:0]                  port_d_out,
	output logic [7:0]                  port_d_oe,
	input  wire logic [PORT_E_PINS-1:0] port_e_in,
	output logic [PORT_E_PINS-1:0]      port_e_out,
	output logic [PORT_E_PINS-1:0]      port_e_oe,
	input  wire logic [6:0]             periph_pending,
	output logic                        periph_irq
);

	typedef struct packed {
		bus_state_t              bus_st;
		logic                    waitrequest;
		logic [DATA_W-1:0]       readdata;
		logic [7:0]              port_d_data;
		logic [7:0]              port_d_dir;
		logic [PORT_E_PINS-1:0]  port_e_data;
		logic [7:0]              port_e_direction_reg;
		logic [7:0]              converter_config_reg;
		logic [7:0]              irq_control_reg;
		logic [7:0]              peripheral_irq_enable_reg;
		logic                    xfer_flag;
		logic                    push_pend;
		logic                    rd_act;
		logic                    wr_act;
		logic [7:0]              pd_out;
		logic [7:0]              pd_oe;
		logic [PORT_E_PINS-1:0]  pe_out;
		logic [PORT_E_PINS-1:0]  pe_oe;
		logic                    irq;
	} port_state_t;

	port_state_t st_r;
	port_state_t st_nxt;

	logic       fifo_in_ready;
	logic       fifo_out_valid;
	logic       fifo_pop;
	logic [7:0] fifo_out_data;
	logic       target_mode;
	logic       rd_now;
	logic       wr_now;
	logic       wr_done;
	logic       strobe_done;
	logic [7:0] irq_sources;
	logic [7:0] status_byte;

	// bytes written by the external processor queue here for software to collect
	rx_byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.in_valid  (st_r.push_pend),
		.in_ready  (fifo_in_ready),
		.in_data   (st_r.port_d_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_out_data)
	);

	assign target_mode = st_r.port_e_direction_reg[PARALLEL_PORT_SELECT_BIT];
	assign rd_now = target_mode && !port_e_in[PIN_READ_N] && !port_e_in[PIN_SELECT_N];
	assign wr_now = target_mode && !port_e_in[PIN_WRITE_N] && !port_e_in[PIN_SELECT_N];
	assign wr_done     = st_r.wr_act && !wr_now;
	assign strobe_done = (st_r.rd_act && !rd_now) || wr_done;
	assign irq_sources = {st_r.xfer_flag, periph_pending};
	assign status_byte = {4'h0, st_r.push_pend, !fifo_in_ready, !fifo_out_valid, st_r.xfer_flag};

	always_comb begin
		st_nxt = st_r;
		fifo_pop = 1'b0;
		st_nxt.waitrequest = 1'b1;
		st_nxt.bus_st = BUS_IDLE;

		// one answer cycle per request; the answer state blocks a second take
		case (st_r.bus_st)
			BUS_IDLE: begin
				if (read || write) begin
					st_nxt.bus_st = BUS_ANSWER;
					st_nxt.waitrequest = 1'b0;
					st_nxt.readdata = UNMAPPED_READ;
				end
				if (read) begin
					case (address)
						OFS_PORT_D_DATA:   st_nxt.readdata = {24'h0, st_r.port_d_data};
						OFS_PORT_E_DATA: begin
							// analog pins read zero
							st_nxt.readdata = {29'h0,
								port_e_in & ~st_r.converter_config_reg[PORT_E_PINS-1:0]};
						end
						OFS_PORT_D_DIR:    st_nxt.readdata = {24'h0, st_r.port_d_dir};
						OFS_PORT_E_DIR:    st_nxt.readdata = {24'h0, st_r.port_e_direction_reg};
						OFS_IRQ_CONTROL:   st_nxt.readdata = {24'h0, st_r.irq_control_reg};
						OFS_CONV_CONFIG:   st_nxt.readdata = {24'h0, st_r.converter_config_reg};
						OFS_PERIPH_IRQ_EN: st_nxt.readdata = {24'h0, st_r.peripheral_irq_enable_reg};
						OFS_PORT_STATUS:   st_nxt.readdata = {24'h0, status_byte};
						OFS_RX_FIFO_DATA: begin
							// an empty queue reads zero and pops nothing
							st_nxt.readdata = {24'h0, fifo_out_valid ? fifo_out_data : 8'h00};
							fifo_pop = fifo_out_valid;
						end
						default:           st_nxt.readdata = UNMAPPED_READ;
					endcase
				end else if (write && byteenable[0]) begin
					case (address)
						OFS_PORT_D_DATA:   st_nxt.port_d_data = writedata[7:0];
						OFS_PORT_E_DATA:   st_nxt.port_e_data = writedata[PORT_E_PINS-1:0];
						OFS_PORT_D_DIR:    st_nxt.port_d_dir = writedata[7:0];
						OFS_PORT_E_DIR:    st_nxt.port_e_direction_reg = writedata[7:0];
						OFS_IRQ_CONTROL:   st_nxt.irq_control_reg = writedata[7:0];
						OFS_CONV_CONFIG:   st_nxt.converter_config_reg = writedata[7:0];
						OFS_PERIPH_IRQ_EN: st_nxt.peripheral_irq_enable_reg = writedata[7:0];
						OFS_PORT_STATUS: begin
							if (writedata[STATUS_XFER_FLAG_BIT]) begin
								st_nxt.xfer_flag = 1'b0;
							end
						end
						default: ;
					endcase
				end
			end
			BUS_ANSWER: begin
				st_nxt.bus_st = BUS_IDLE;
			end
			default: begin
				st_nxt.bus_st = BUS_IDLE;
			end
		endcase

		// external write overrides a software write in the same cycle
		st_nxt.rd_act = rd_now;
		st_nxt.wr_act = wr_now;
		if (wr_now) begin
			st_nxt.port_d_data = port_d_in;
		end

		// a full queue stalls the push until a slot frees
		if (st_r.push_pend && fifo_in_ready) begin
			st_nxt.push_pend = 1'b0;
		end
		if (wr_done) begin
			st_nxt.push_pend = 1'b1;
		end

		// a finished strobe beats a clear in the same cycle
		if (strobe_done) begin
			st_nxt.xfer_flag = 1'b1;
		end

		if (rd_now) begin
			st_nxt.pd_oe = 8'hFF;
			st_nxt.pd_out = st_r.port_d_data;
		end else if (target_mode) begin
			st_nxt.pd_oe = 8'h00;
			st_nxt.pd_out = st_r.port_d_data;
		end else begin
			st_nxt.pd_oe = ~st_r.port_d_dir;
			st_nxt.pd_out = st_r.port_d_data;
		end

		// direction bits govern port E whether digital or analog; strobe mode forces inputs
		st_nxt.pe_oe = target_mode ? '0 : ~st_r.port_e_direction_reg[PORT_E_PINS-1:0];
		st_nxt.pe_out = st_r.port_e_data;

		st_nxt.irq = st_r.irq_control_reg[PERIPH_IRQ_GATE_BIT]
			&& |(st_r.peripheral_irq_enable_reg & irq_sources);
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r.bus_st                    <= BUS_IDLE;
			st_r.waitrequest               <= 1'b1;
			st_r.readdata                  <= UNMAPPED_READ;
			st_r.port_d_data               <= RST_PORT_DATA;
			st_r.port_d_dir                <= RST_PORT_D_DIR;
			st_r.port_e_data               <= RST_PORT_DATA[PORT_E_PINS-1:0];
			st_r.port_e_direction_reg      <= RST_PORT_E_DIR;
			st_r.converter_config_reg      <= RST_CONV_CONFIG;
			st_r.irq_control_reg           <= RST_IRQ_CONTROL;
			st_r.peripheral_irq_enable_reg <= RST_PERIPH_IRQ_EN;
			st_r.xfer_flag                 <= 1'b0;
			st_r.push_pend                 <= 1'b0;
			st_r.rd_act                    <= 1'b0;
			st_r.wr_act                    <= 1'b0;
			st_r.pd_out                    <= 8'h00;
			st_r.pd_oe                     <= 8'h00;
			st_r.pe_out                    <= '0;
			st_r.pe_oe                     <= '0;
			st_r.irq                       <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign readdata    = st_r.readdata;
	assign waitrequest = st_r.waitrequest;
	assign port_d_out  = st_r.pd_out;
	assign port_d_oe   = st_r.pd_oe;
	assign port_e_out  = st_r.pe_out;
	assign port_e_oe   = st_r.pe_oe;
	assign periph_irq  = st_r.irq;

endmodule : parallel_target_port_control

`default_nettype wire

// File: sim/parallel_target_port_control_sva.sv
/* ptp_sva: bus, pin and interrupt relations of the port block.
   Sees only the top ports; one clock domain; bound at the foot. */
`timescale 1ns/1ps
`default_nettype none
module ptp_sva (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [7:0]  port_d_in,
	input wire logic [7:0]  port_d_out,
	input wire logic [7:0]  port_d_oe,
	input wire logic [2:0]  port_e_in,
	input wire logic [2:0]  port_e_out,
	input wire logic [2:0]  port_e_oe,
	input wire logic [6:0]  periph_pending,
	input wire logic        periph_irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic [1:0] wr_cnt_r;
	wire        rd_sel = !port_e_in[0] && !port_e_in[2];
	wire        wr_sel = !port_e_in[1] && !port_e_in[2];
	// writes taken, saturating: gate and enable need two
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			wr_cnt_r <= 2'h0;
		else if (write && waitrequest && wr_cnt_r != 2'h3)
			wr_cnt_r <= wr_cnt_r + 2'h1;
	end
	answer_next_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus answer missing");
	wait_pulse_a: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	upper_zero_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
		else $error("readdata upper bits set");
	reset_quiet_a: assert property (wr_cnt_r == 2'h0 |-> port_e_oe == 3'h0)
		else $error("port E driven before setup");
	e_dir_cause_a: assert property ($changed(port_e_oe) |-> $past(write) || $past(write, 2))
		else $error("port E direction moved alone");
	drive_cause_a: assert property ($rose(port_d_oe[0]) |->
		$past(write) || $past(write, 2) || $past(rd_sel)) else $error("port D drive without cause");
	latch_cause_a: assert property ($changed(port_d_out) |->
		$past(write) || $past(write, 2) || $past(wr_sel) || $past(wr_sel, 2))
		else $error("port D latch without cause");
	irq_gate_a: assert property (periph_irq |-> wr_cnt_r[1])
		else $error("interrupt while gate never set");
	cover property ($rose(port_d_oe[0]));
	cover property ($rose(periph_irq));
	cover property (write && !waitrequest);
endmodule : ptp_sva
bind parallel_target_port_control ptp_sva ptp_sva_inst (.core_clk, .arst_n, .address, .read,
	.write, .writedata, .byteenable, .readdata, .waitrequest, .port_d_in, .port_d_out,
	.port_d_oe, .port_e_in, .port_e_out, .port_e_oe, .periph_pending, .periph_irq);
`default_nettype wire

// File: sim/ext_cpu_model.sv
/* ext_cpu_model: external processor on the strobe pins and port D.
   Assumes the bench calls xfer right after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module ext_cpu_model (
	input wire logic       core_clk,
	input wire logic [7:0] port_d_out,
	input wire logic [7:0] port_d_oe,
	input wire logic [2:0] port_e_out,
	input wire logic [2:0] port_e_oe,
	output logic     [7:0] port_d_in,
	output logic     [2:0] port_e_in
);
	logic [7:0] cpu_d = 8'h00;
	logic       cpu_oe = 1'b0;
	logic [2:0] strobe_n = 3'h7;
	// released lines show the inverse so a stale byte never passes
	assign port_d_in = (port_d_oe & port_d_out) | (~port_d_oe & (cpu_oe ? cpu_d : ~cpu_d));
	assign port_e_in = (port_e_oe & port_e_out) | (~port_e_oe & strobe_n);
	// s: {select_n, write_n, read_n}; strobe held 3 cycles, 2 idle after
	task automatic xfer(input logic [2:0] s, input logic [7:0] d, output logic [7:0] q);
		strobe_n <= s;
		cpu_d <= d;
		cpu_oe <= s[0];
		repeat (3) @(posedge core_clk);
		q = port_d_in;
		strobe_n <= 3'h7;
		cpu_oe <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : xfer
endmodule : ext_cpu_model
`default_nettype wire

// File: sim/parallel_target_port_control_tb.sv
/* parallel_target_port_control_tb: register, strobe, queue and interrupt tests.
   Assumes the design package and the external processor model. */
`timescale 1ns/1ps
`default_nettype none
module parallel_target_port_control_tb;
	import parallel_target_port_pkg::*;
	logic        core_clk, arst_n, read, write, waitrequest, periph_irq;
	logic [7:0]  address, port_d_in, port_d_out, port_d_oe, q;
	logic [31:0] writedata, readdata, v;
	logic [2:0]  port_e_in, port_e_out, port_e_oe;
	logic [6:0]  periph_pending;
	int          miscompares = 0;
	int          tests_run = 0;
	int          cycles = 0;
	parallel_target_port_control parallel_target_port_control_inst (.core_clk, .arst_n,
		.address, .read, .write, .writedata, .byteenable(4'h1), .readdata, .waitrequest,
		.port_d_in, .port_d_out, .port_d_oe, .port_e_in, .port_e_out, .port_e_oe,
		.periph_pending, .periph_irq);
	ext_cpu_model ext_cpu_model_inst (.core_clk, .port_d_out, .port_d_oe, .port_e_out,
		.port_e_oe, .port_d_in, .port_e_in);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic bus(input logic rw, input logic [7:0] a, input logic [31:0] wd);
		read <= !rw;
		write <= rw;
		address <= a;
		writedata <= wd;
		do @(posedge core_clk); while (waitrequest !== 1'b0);
		v = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge core_clk);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(v, exp);
	endtask : rd
	task automatic close_out();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// the whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			close_out();
		end
	end
	initial begin
		arst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0;
		periph_pending = 7'h00;
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		rd(OFS_PERIPH_IRQ_EN, 32'h0);
		rd(OFS_PORT_E_DATA, 32'h0);
		rd(8'h00, 32'h0);
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, OFS_PERIPH_IRQ_EN, 32'h1 << i);
			rd(OFS_PERIPH_IRQ_EN, 32'h1 << i);
		end
		$display("test registers done");
		bus(1'b1, OFS_CONV_CONFIG, 32'h0);
		bus(1'b1, OFS_PORT_E_DIR, 32'h2);
		bus(1'b1, OFS_PORT_E_DATA, 32'h7);
		check(port_e_oe, 32'h5);
		rd(OFS_PORT_E_DATA, 32'h7);
		bus(1'b1, OFS_CONV_CONFIG, 32'h7);
		check(port_e_oe, 32'h5);
		rd(OFS_PORT_E_DATA, 32'h0);
		$display("test port E done");
		bus(1'b1, OFS_CONV_CONFIG, 32'h0);
		bus(1'b1, OFS_PORT_E_DIR, 32'h17);
		check(port_e_oe, 32'h0);
		ext_cpu_model_inst.xfer(3'b001, 8'hA5, q);
		rd(OFS_PORT_D_DATA, 32'hA5);
		ext_cpu_model_inst.xfer(3'b101, 8'h3C, q);
		rd(OFS_PORT_D_DATA, 32'hA5);
		ext_cpu_model_inst.xfer(3'b010, 8'h00, q);
		check(q, 32'hA5);
		check(port_d_oe, 32'h0);
		rd(OFS_RX_FIFO_DATA, 32'hA5);
		$display("test strobes done");
		bus(1'b1, OFS_PERIPH_IRQ_EN, 32'h80);
		check(periph_irq, 32'h0);
		bus(1'b1, OFS_IRQ_CONTROL, 32'h40);
		check(periph_irq, 32'h1);
		bus(1'b1, OFS_PORT_STATUS, 32'h1);
		check(periph_irq, 32'h0);
		periph_pending <= 7'h40;
		bus(1'b1, OFS_PERIPH_IRQ_EN, 32'h40);
		check(periph_irq, 32'h1);
		bus(1'b1, OFS_IRQ_CONTROL, 32'h0);
		check(periph_irq, 32'h0);
		$display("test interrupts done");
		// one byte beyond depth waits as a stalled push
		for (int i = 0; i < 33; i++)
			ext_cpu_model_inst.xfer(3'b001, 8'(i), q);
		bus(1'b0, OFS_PORT_STATUS, 32'h0);
		check(v[3:2], 32'h3);
		for (int i = 0; i < 33; i++)
			rd(OFS_RX_FIFO_DATA, 32'(i));
		bus(1'b0, OFS_PORT_STATUS, 32'h0);
		check(v[3:1], 32'h1);
		$display("test queue done");
		close_out();
	end
endmodule : parallel_target_port_control_tb
`default_nettype wire
